// [charger_misc_pkg.sv]
// Constants, types and field layout for the charger miscellaneous configuration registers
package charger_misc_pkg;
   localparam logic [7:0] ADDR_LOW_POWER_SCAN_PERIOD = 8'h4B;
   localparam logic [7:0] ADDR_SOLAR_SCAN_PERIOD = 8'h4C;
   localparam logic [7:0] ADDR_CHARGE_OPTION_FLAGS = 8'h4D;
   localparam logic [7:0] RST_LOW_POWER_SCAN_PERIOD = 8'h00;
   localparam logic [7:0] RST_SOLAR_SCAN_PERIOD = 8'h00;
   localparam logic [7:0] RST_CHARGE_OPTION_FLAGS = 8'h00;
   localparam logic [7:0] OPTION_WRITE_MASK = 8'h1F;
   localparam int BIT_REDUCED_STAGE2 = 4;
   localparam int BIT_LOW_POWER = 3;
   localparam int BIT_SUPPLY_S3 = 2;
   localparam int BIT_PANEL_S3 = 1;
   localparam int BIT_TEMP_COMP = 0;
   localparam int CLK_HZ = 40_000_000;
   localparam int STEP_CENTISEC = 1666;
   localparam int STEP_CYCLES = CLK_HZ / 100 * STEP_CENTISEC;
   localparam int PCT_S1_TO_S2 = 98;
   localparam int PCT_S2_TO_S1 = 95;
   typedef struct packed {
      logic reducedStage2VoltageEn;
      logic lowPowerEnable;
      logic supplyStage3Permit;
      logic panelStage3Permit;
      logic tempCompEnable;
   } option_flags_s;
   typedef struct packed {
      logic [15:0] stage2Limit;
      logic [15:0] s1ToS2Threshold;
      logic [15:0] s2ToS1Threshold;
      logic stage3Allowed;
      logic tempCompActive;
   } charge_ctrl_s;
endpackage : charger_misc_pkg

// [scan_timer.sv]
// Interval counter that requests timed full panel scans
`timescale 1ns/1ps
module scan_timer #(
   parameter int STEP_CYCLES = charger_misc_pkg::STEP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] period,
   input wire logic enable,
   input wire logic reload,
   input wire logic scanDone,
   output logic scanRequest
);
   import charger_misc_pkg::*;
   logic [31:0] prescale_r, prescale_nxt;
   logic [7:0] steps_r, steps_nxt;
   logic scanRequest_r, scanRequest_nxt;
   always_comb begin
      prescale_nxt = prescale_r;
      steps_nxt = steps_r;
      scanRequest_nxt = scanRequest_r;
      if (!enable || period == 8'h00) begin
         prescale_nxt = '0;
         steps_nxt = '0;
         scanRequest_nxt = 1'b0;
      end else if (reload || scanDone) begin
         prescale_nxt = '0;
         steps_nxt = '0;
         scanRequest_nxt = 1'b0;
      end else if (!scanRequest_r) begin
         if (prescale_r == 32'(STEP_CYCLES - 1)) begin
            prescale_nxt = '0;
            if (steps_r + 8'h01 >= period) begin
               scanRequest_nxt = 1'b1;
            end else begin
               steps_nxt = steps_r + 8'h01;
            end
         end else begin
            prescale_nxt = prescale_r + 32'h1;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prescale_r <= '0;
         steps_r <= '0;
         scanRequest_r <= 1'b0;
      end else begin
         prescale_r <= prescale_nxt;
         steps_r <= steps_nxt;
         scanRequest_r <= scanRequest_nxt;
      end
   end
   assign scanRequest = scanRequest_r;
endmodule : scan_timer

// [charger_misc_config_regs.sv]
// Miscellaneous configuration registers with scan timing and charge option decode
`timescale 1ns/1ps
module charger_misc_config_regs #(
   parameter int STEP_CYCLES = charger_misc_pkg::STEP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regHit,
   input wire logic solarPowered,
   input wire logic startupScan,
   input wire logic stageTransitionScan,
   input wire logic scanDone,
   input wire logic [15:0] stage2TargetVoltage,
   input wire logic [15:0] stage3TargetVoltage,
   output logic fullScanRequest,
   output logic lowPowerMode,
   output charger_misc_pkg::option_flags_s optionFlags,
   output charger_misc_pkg::charge_ctrl_s chargeCtrl
);
   import charger_misc_pkg::*;

   logic [7:0] lowPowerScanPeriod_r, lowPowerScanPeriod_nxt;
   logic [7:0] solarScanPeriod_r, solarScanPeriod_nxt;
   logic [4:0] chargeOptionFlags_r, chargeOptionFlags_nxt;
   logic lowPowerPrev_r, lowPowerPrev_nxt;
   logic solarMeta_r, solarSync_r;
   logic fullScanRequest_r, fullScanRequest_nxt;
   charge_ctrl_s chargeCtrl_r, chargeCtrl_nxt;
   logic [7:0] activePeriod;
   logic modeChange;
   logic timedRequest;

   function automatic logic [15:0] percentOf(input logic [15:0] v, input int pct);
      logic [23:0] prod;
      prod = 24'(v) * 24'(pct);
      return 16'(prod / 24'd100);
   endfunction : percentOf

   // Solar status comes from the analog power path, so it is synchronised
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         solarMeta_r <= 1'b0;
         solarSync_r <= 1'b0;
      end else begin
         solarMeta_r <= solarPowered;
         solarSync_r <= solarMeta_r;
      end
   end

   always_comb begin
      lowPowerScanPeriod_nxt = lowPowerScanPeriod_r;
      solarScanPeriod_nxt = solarScanPeriod_r;
      chargeOptionFlags_nxt = chargeOptionFlags_r;
      if (regWrite) begin
         unique case (regAddr)
            ADDR_LOW_POWER_SCAN_PERIOD: lowPowerScanPeriod_nxt = regWdata;
            ADDR_SOLAR_SCAN_PERIOD: solarScanPeriod_nxt = regWdata;
            ADDR_CHARGE_OPTION_FLAGS: chargeOptionFlags_nxt = regWdata[4:0] & OPTION_WRITE_MASK[4:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      regHit = (regAddr == ADDR_LOW_POWER_SCAN_PERIOD) || (regAddr == ADDR_SOLAR_SCAN_PERIOD) ||
               (regAddr == ADDR_CHARGE_OPTION_FLAGS);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else begin
         unique case (regAddr)
            ADDR_LOW_POWER_SCAN_PERIOD: regRdata <= lowPowerScanPeriod_r;
            ADDR_SOLAR_SCAN_PERIOD: regRdata <= solarScanPeriod_r;
            ADDR_CHARGE_OPTION_FLAGS: regRdata <= {3'b000, chargeOptionFlags_r};
            default: regRdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lowPowerScanPeriod_r <= RST_LOW_POWER_SCAN_PERIOD;
         solarScanPeriod_r <= RST_SOLAR_SCAN_PERIOD;
         chargeOptionFlags_r <= RST_CHARGE_OPTION_FLAGS[4:0];
      end else begin
         lowPowerScanPeriod_r <= lowPowerScanPeriod_nxt;
         solarScanPeriod_r <= solarScanPeriod_nxt;
         chargeOptionFlags_r <= chargeOptionFlags_nxt;
      end
   end

   assign lowPowerMode = chargeOptionFlags_r[BIT_LOW_POWER] & solarSync_r;
   assign activePeriod = lowPowerMode ? lowPowerScanPeriod_r : solarScanPeriod_r;
   assign modeChange = lowPowerPrev_r != lowPowerMode;
   assign lowPowerPrev_nxt = lowPowerMode;

   scan_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_scan_timer (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .period(activePeriod),
      .enable(solarSync_r),
      .reload(modeChange),
      .scanDone(scanDone),
      .scanRequest(timedRequest)
   );

   always_comb begin
      fullScanRequest_nxt = fullScanRequest_r;
      // A timed request still standing as its own scan ends must not start a second scan
      if (!solarSync_r) begin
         fullScanRequest_nxt = 1'b0;
      end else if (startupScan || stageTransitionScan || (timedRequest && !scanDone)) begin
         fullScanRequest_nxt = 1'b1;
      end else if (scanDone) begin
         fullScanRequest_nxt = 1'b0;
      end
   end

   always_comb begin
      logic [15:0] target;
      target = 16'h0000;
      target = chargeOptionFlags_r[BIT_REDUCED_STAGE2] ? stage3TargetVoltage : stage2TargetVoltage;
      chargeCtrl_nxt.stage2Limit = target;
      chargeCtrl_nxt.s1ToS2Threshold = percentOf(target, PCT_S1_TO_S2);
      chargeCtrl_nxt.s2ToS1Threshold = percentOf(target, PCT_S2_TO_S1);
      // Stage 0/1 and undervoltage thresholds stay with the stage-2 target outside this block
      chargeCtrl_nxt.stage3Allowed = solarSync_r ? chargeOptionFlags_r[BIT_PANEL_S3]
                                                 : chargeOptionFlags_r[BIT_SUPPLY_S3];
      chargeCtrl_nxt.tempCompActive = chargeOptionFlags_r[BIT_TEMP_COMP];
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lowPowerPrev_r <= 1'b0;
         fullScanRequest_r <= 1'b0;
         chargeCtrl_r <= '0;
      end else begin
         lowPowerPrev_r <= lowPowerPrev_nxt;
         fullScanRequest_r <= fullScanRequest_nxt;
         chargeCtrl_r <= chargeCtrl_nxt;
      end
   end

   assign fullScanRequest = fullScanRequest_r;
   assign chargeCtrl = chargeCtrl_r;
   assign optionFlags = option_flags_s'(chargeOptionFlags_r);
endmodule : charger_misc_config_regs

// [charger_misc_config_regs_asserts.sv]
// Checker for the charger configuration register ports
`timescale 1ns/1ps
module charger_misc_config_regs_asserts (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdata,
   input wire logic solarPowered,
   input wire logic [15:0] stage2TargetVoltage,
   input wire logic [15:0] stage3TargetVoltage,
   input wire logic fullScanRequest,
   input wire logic lowPowerMode,
   input wire charger_misc_pkg::option_flags_s optionFlags,
   input wire charger_misc_pkg::charge_ctrl_s chargeCtrl
);
   import charger_misc_pkg::*;
   logic [31:0] selV;
   assign selV = {16'h0000, optionFlags.reducedStage2VoltageEn ? stage3TargetVoltage : stage2TargetVoltage};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Three quiet cycles cover the register stage behind the decode
   sequence quiet;
      ($stable(optionFlags) && $stable(stage2TargetVoltage) && $stable(stage3TargetVoltage))[*3];
   endsequence
   rsvd_zero_a:
      assert property (regAddr == 8'h4D |=> regRdata[7:5] == 3'h0) else $error("reserved bits set");
   stage2_limit_a:
      assert property (quiet |-> chargeCtrl.stage2Limit == selV[15:0]) else $error("stage 2 limit");
   rise_thresh_a:
      assert property (quiet |-> chargeCtrl.s1ToS2Threshold == 16'(selV * 98 / 100)) else $error("rise threshold");
   fall_thresh_a:
      assert property (quiet |-> chargeCtrl.s2ToS1Threshold == 16'(selV * 95 / 100)) else $error("fall threshold");
   panel_s3_a:
      assert property ((solarPowered && $stable(optionFlags))[*5] |-> chargeCtrl.stage3Allowed
         == optionFlags.panelStage3Permit) else $error("panel stage 3");
   supply_s3_a:
      assert property ((!solarPowered && $stable(optionFlags))[*5] |-> chargeCtrl.stage3Allowed
         == optionFlags.supplyStage3Permit) else $error("supply stage 3");
   no_panel_a:
      assert property (!solarPowered [*5] |-> !fullScanRequest) else $error("scan without panel");
   low_power_a:
      assert property ((solarPowered && optionFlags.lowPowerEnable)[*4] |-> lowPowerMode) else $error("low power");
endmodule : charger_misc_config_regs_asserts
bind charger_misc_config_regs charger_misc_config_regs_asserts i_chk (.clk_sys, .rstn, .regAddr, .regRdata,
   .solarPowered, .stage2TargetVoltage, .stage3TargetVoltage, .fullScanRequest, .lowPowerMode, .optionFlags,
   .chargeCtrl);

// [scan_engine_model.sv]
// Behavioural scan engine that finishes each requested full panel scan
`timescale 1ns/1ps
module scan_engine_model #(
   parameter int LAT = 3
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic fullScanRequest,
   output logic scanDone
);
   int cnt;
   // Done is one pulse so a request still standing is not finished twice
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         scanDone <= 1'b0;
      end else begin
         scanDone <= fullScanRequest && cnt == LAT;
         cnt <= (fullScanRequest && cnt < LAT) ? cnt + 1 : 0;
      end
   end
endmodule : scan_engine_model

// [tb_top.sv]
// Self-checking bench for the charger configuration registers
`timescale 1ns/1ps
module tb_top;
   import charger_misc_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic regWrite = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic solarPowered = 1'b0;
   logic startupScan = 1'b0;
   logic stageScan = 1'b0;
   logic [15:0] s2V = 16'h03E8;
   logic [15:0] s3V = 16'h0384;
   logic [7:0] regRdata;
   logic regHit, scanDone, fullScanRequest, lowPowerMode;
   option_flags_s optionFlags;
   charge_ctrl_s chargeCtrl;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   charger_misc_config_regs #(.STEP_CYCLES(4)) i_dut (.clk_sys, .rstn, .regWrite, .regAddr, .regWdata, .regRdata,
      .regHit, .solarPowered, .startupScan, .stageTransitionScan(stageScan), .scanDone, .stage2TargetVoltage(s2V),
      .stage3TargetVoltage(s3V), .fullScanRequest, .lowPowerMode, .optionFlags, .chargeCtrl);
   scan_engine_model #(.LAT(3)) i_scan (.clk_sys, .rstn, .fullScanRequest, .scanDone);
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   // The whole run needs about 200 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Strobe is dropped for one cycle so it is never driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      regAddr <= a;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(regRdata, exp);
      chk(regHit, hit);
      @(posedge clk_sys);
   endtask : rd
   // Sampled at the falling edge where the registered request has settled
   task automatic watch(input logic lvl, input int lim, output int n);
      n = 0;
      while (fullScanRequest !== lvl && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
   endtask : watch
   task automatic t_regs();
      rd(8'h4B, 8'h00, 1'b1);
      rd(8'h4C, 8'h00, 1'b1);
      wr(8'h4B, 8'h0B);
      wr(8'h4C, 8'h48);
      wr(8'h4D, 8'hFF);
      wr(8'h4E, 8'h5A);
      rd(8'h4B, 8'h0B, 1'b1);
      rd(8'h4C, 8'h48, 1'b1);
      rd(8'h4D, 8'h1F, 1'b1);
      rd(8'h4E, 8'h00, 1'b0);
   endtask : t_regs
   // Bit 4 alone also leaves both stage-3 permits cleared
   // Termination enables live outside this block, so none is ever set here
   task automatic t_opts();
      for (int i = 0; i < 5; i++) begin
         wr(8'h4D, 8'(1 << i));
         repeat (2) @(posedge clk_sys);
         #1;
         chk(16'(optionFlags), 16'(1 << i));
         chk(chargeCtrl.stage2Limit, i == 4 ? s3V : s2V);
         chk(chargeCtrl.s1ToS2Threshold, i == 4 ? 16'h0372 : 16'h03D4);
         chk(chargeCtrl.s2ToS1Threshold, i == 4 ? 16'h0357 : 16'h03B6);
         chk(chargeCtrl.stage3Allowed, i == 2);
         chk(chargeCtrl.tempCompActive, i == 0);
         @(posedge clk_sys);
      end
   endtask : t_opts
   task automatic t_scan();
      int n;
      solarPowered <= 1'b1;
      wr(8'h4B, 8'h00);
      wr(8'h4D, 8'h02);
      // Two steps is short only because each step is shrunk to four cycles
      wr(8'h4C, 8'h02);
      watch(1'b1, 40, n);
      chk(chargeCtrl.stage3Allowed, 1'b1);
      watch(1'b0, 20, n);
      chk(16'(n), 16'd5);
      watch(1'b1, 40, n);
      chk(16'(n >= 6 && n <= 14), 16'h0001);
      watch(1'b0, 20, n);
      // Solar period stays nonzero so only the low-power period can hold scans off
      wr(8'h4D, 8'h0A);
      chk(lowPowerMode, 1'b1);
      watch(1'b1, 40, n);
      chk(16'(n), 16'd40);
      startupScan <= 1'b1;
      @(posedge clk_sys);
      startupScan <= 1'b0;
      watch(1'b1, 6, n);
      chk(fullScanRequest, 1'b1);
      watch(1'b0, 20, n);
      stageScan <= 1'b1;
      @(posedge clk_sys);
      stageScan <= 1'b0;
      watch(1'b1, 6, n);
      chk(fullScanRequest, 1'b1);
      watch(1'b0, 20, n);
      solarPowered <= 1'b0;
      repeat (6) @(posedge clk_sys);
      startupScan <= 1'b1;
      @(posedge clk_sys);
      startupScan <= 1'b0;
      watch(1'b1, 20, n);
      chk(16'(n), 16'd20);
   endtask : t_scan
   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_opts();
      t_scan();
      print_verdict();
   end
endmodule : tb_top
